// *** core/led_brightness_code_select.sv ***
// Notes on behaviour
// - With unison off each sink takes the code of its own brightness register.
// - Brightness registers are 8 bits and only bits 6..0 steer the current code.
// - With unison on the secondary register is ignored and the primary code drives both.
// - Each code maps through a fixed rising exponential table, 0 to zero, 127 to full scale.
// - Unison select is bit 2 of the general purpose register.
`timescale 1ns/1ps
`default_nettype none
module led_brightness_code_select
  import led_code_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [ADDR_W-1:0] wb_adr_in,
  input  wire logic [31:0]       wb_dat_in,
  input  wire logic [3:0]        wb_sel_in,
  output logic [31:0]            wb_dat_out,
  output logic                   wb_ack_out,
  output logic [CODE_W-1:0]      primary_sink_code_out,
  output logic [CODE_W-1:0]      secondary_sink_code_out,
  output logic [FRAC_W-1:0]      primary_sink_frac_out,
  output logic [FRAC_W-1:0]      secondary_sink_frac_out,
  output logic                   unison_select_out
);

  function automatic logic [FRAC_W-1:0] code_frac(input logic [CODE_W-1:0] code);
    code_frac = FRAC_TABLE[code];
  endfunction : code_frac

  logic [CODE_W-1:0] primary_brightness_code_r;
  logic [CODE_W-1:0] secondary_brightness_code_r;
  logic [5:0]        gen_purpose_r;
  logic              ack_r;
  logic [7:0]        rdata_r;
  logic [CODE_W-1:0] pri_out_r;
  logic [CODE_W-1:0] sec_out_r;
  logic [FRAC_W-1:0] pri_frac_r;
  logic [FRAC_W-1:0] sec_frac_r;

  // Request taken once; ack drops the cycle after it is given
  wire               req_take   = wb_cyc_in & wb_stb_in & ~ack_r;
  wire               wr_take    = req_take & wb_we_in & wb_sel_in[0];
  wire               hit_gp     = (wb_adr_in == GEN_PURPOSE_OFS);
  wire               hit_pri    = (wb_adr_in == PRIMARY_CODE_OFS);
  wire               hit_sec    = (wb_adr_in == SECOND_CODE_OFS);
  wire               unison     = gen_purpose_r[UNISON_BIT];
  wire [CODE_W-1:0]  wr_code    = wb_dat_in[CODE_W-1:0];
  wire [CODE_W-1:0]  sec_source = unison ? primary_brightness_code_r
                                         : secondary_brightness_code_r;
  // Unmapped addresses still ack and read zero, so software never hangs
  wire [7:0]         rd_mux     = hit_gp  ? {GP_FIXED_ONES, gen_purpose_r} :
                                  hit_pri ? {BRIGHT_MSB_READ, primary_brightness_code_r} :
                                  hit_sec ? {BRIGHT_MSB_READ, secondary_brightness_code_r} :
                                  8'h00;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      gen_purpose_r               <= GEN_PURPOSE_RST[5:0];
      primary_brightness_code_r   <= BRIGHT_RST[CODE_W-1:0];
      secondary_brightness_code_r <= BRIGHT_RST[CODE_W-1:0];
    end else if (wr_take) begin
      if (hit_gp)
        gen_purpose_r <= wb_dat_in[5:0] & GP_RW_MASK;
      if (hit_pri)
        primary_brightness_code_r <= wr_code;
      if (hit_sec)
        secondary_brightness_code_r <= wr_code;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ack_r   <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ack_r   <= req_take;
      rdata_r <= req_take ? rd_mux : 8'h00;
    end
  end

  // Registered codes cost a cycle but keep sink drive glitch-free
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pri_out_r  <= BRIGHT_RST[CODE_W-1:0];
      sec_out_r  <= BRIGHT_RST[CODE_W-1:0];
      pri_frac_r <= code_frac(BRIGHT_RST[CODE_W-1:0]);
      sec_frac_r <= code_frac(BRIGHT_RST[CODE_W-1:0]);
    end else begin
      pri_out_r  <= primary_brightness_code_r;
      sec_out_r  <= sec_source;
      pri_frac_r <= code_frac(primary_brightness_code_r);
      sec_frac_r <= code_frac(sec_source);
    end
  end

  assign wb_ack_out              = ack_r;
  assign wb_dat_out              = {24'h000000, rdata_r};
  assign primary_sink_code_out   = pri_out_r;
  assign secondary_sink_code_out = sec_out_r;
  assign primary_sink_frac_out   = pri_frac_r;
  assign secondary_sink_frac_out = sec_frac_r;
  assign unison_select_out       = unison;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  chk_indep_secondary_follow: assert property (
    !unison |=> sec_out_r == $past(secondary_brightness_code_r))
    else $error("secondary sink not following its own register");
  chk_msb_no_effect: assert property (
    wr_take && hit_pri |=> primary_brightness_code_r == $past(wb_dat_in[CODE_W-1:0]))
    else $error("primary code not low seven bits of write");
  chk_unison_shared_code: assert property (
    unison |=> sec_out_r == pri_out_r)
    else $error("unison mode sinks differ");
  chk_table_ends: assert property (
    (pri_out_r == 7'h00 |-> pri_frac_r == 17'h0) and
    (pri_out_r == 7'h7f |-> pri_frac_r == 17'd100000))
    else $error("table end points wrong");
  chk_table_monotonic: assert property (
    pri_out_r > sec_out_r |-> pri_frac_r > sec_frac_r)
    else $error("table not rising");
  chk_unison_bit_pos: assert property (
    wr_take && hit_gp |=> unison_select_out == $past(wb_dat_in[2]))
    else $error("unison bit not bit 2");
  chk_read_msb_one: assert property (
    req_take && !wb_we_in && (hit_pri || hit_sec) |=> wb_ack_out ##0 wb_dat_out[7])
    else $error("brightness read bit 7 not one");
  chk_ack_one_cycle: assert property (
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");

  cov_unison_write: cover property (wr_take && hit_gp && wb_dat_in[2]);
  cov_secondary_read: cover property (req_take && !wb_we_in && hit_sec);
  cov_full_scale: cover property (pri_frac_r == 17'd100000);

endmodule : led_brightness_code_select
`default_nettype wire

// *** core/led_code_pkg.sv ***
`default_nettype none
package led_code_pkg;
  localparam int        ADDR_W          = 8;
  localparam int        CODE_W          = 7;
  localparam int        FRAC_W          = 17;
  localparam logic [7:0] GEN_PURPOSE_OFS  = 8'h10;
  localparam logic [7:0] PRIMARY_CODE_OFS = 8'ha0;
  localparam logic [7:0] SECOND_CODE_OFS  = 8'hb0;
  localparam logic [7:0] GEN_PURPOSE_RST  = 8'hc0;
  localparam logic [7:0] BRIGHT_RST       = 8'h80;
  localparam int        UNISON_BIT      = 2;
  localparam logic [5:0] GP_RW_MASK       = 6'h3f;
  localparam logic [1:0] GP_FIXED_ONES    = 2'h3;
  localparam logic       BRIGHT_MSB_READ  = 1'h1;
  // Current as thousandths of a percent of full_scale_current
  localparam logic [FRAC_W-1:0] FRAC_TABLE [128] = '{
    17'h0, 17'd166, 17'd175, 17'd184, 17'd194, 17'd204, 17'd214, 17'd226,
    17'd237, 17'd250, 17'd263, 17'd276, 17'd291, 17'd306, 17'd322, 17'd339,
    17'd356, 17'd375, 17'd394, 17'd415, 17'd436, 17'd459, 17'd483, 17'd508,
    17'd535, 17'd563, 17'd592, 17'd623, 17'd655, 17'd689, 17'd725, 17'd763,
    17'd803, 17'd845, 17'd889, 17'd935, 17'd984, 17'd1035, 17'd1089, 17'd1146,
    17'd1205, 17'd1268, 17'd1334, 17'd1404, 17'd1477, 17'd1554, 17'd1635, 17'd1720,
    17'd1809, 17'd1904, 17'd2003, 17'd2107, 17'd2217, 17'd2332, 17'd2454, 17'd2582,
    17'd2716, 17'd2858, 17'd3007, 17'd3163, 17'd3328, 17'd3502, 17'd3684, 17'd3876,
    17'd4078, 17'd4290, 17'd4514, 17'd4749, 17'd4996, 17'd5257, 17'd5531, 17'd5819,
    17'd6122, 17'd6441, 17'd6776, 17'd7129, 17'd7501, 17'd7892, 17'd8303, 17'd8735,
    17'd9191, 17'd9669, 17'd10173, 17'd10703, 17'd11261, 17'd11847, 17'd12465,
    17'd13114, 17'd13797, 17'd14516, 17'd15272, 17'd16068, 17'd16905, 17'd17786,
    17'd18713, 17'd19687, 17'd20713, 17'd21792, 17'd22928, 17'd24122, 17'd25379,
    17'd26701, 17'd28092, 17'd29556, 17'd31096, 17'd32716, 17'd34420, 17'd36213,
    17'd38100, 17'd40085, 17'd42173, 17'd44371, 17'd46682, 17'd49114, 17'd51673,
    17'd54365, 17'd57198, 17'd60178, 17'd63313, 17'd66611, 17'd70082, 17'd73733,
    17'd77574, 17'd81616, 17'd85868, 17'd90341, 17'd95048, 17'd100000
  };
endpackage : led_code_pkg
`default_nettype wire

// *** verification/led_brightness_code_select_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module led_brightness_code_select_test;
  import led_code_pkg::*;
  logic        mclk_in = 0, rst_n_in = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rd;
  wire logic [31:0] rdat;
  wire logic        ack, unison_select;
  wire logic [6:0]  pc, sc;
  wire logic [16:0] pf, sf;
  int n_errors = 0, cmp_count = 0;
  always #5 mclk_in = ~mclk_in;
  led_brightness_code_select DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel),
    .wb_dat_out(rdat), .wb_ack_out(ack), .primary_sink_code_out(pc),
    .secondary_sink_code_out(sc), .primary_sink_frac_out(pf),
    .secondary_sink_frac_out(sf), .unison_select_out(unison_select));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until ack is sampled, then idles one cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge mclk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h1, 32'h0);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk_in);
  endtask : bus
  // Frac expectations only for the codes driven here
  function automatic logic [31:0] fr(input logic [6:0] c);
    return c == 7'h01 ? 166 : c == 7'h40 ? 4078 : c == 7'h7f ? 100000 : 0;
  endfunction : fr
  task automatic sinks(input logic [6:0] p, input logic [6:0] s);
    repeat (2) @(posedge mclk_in);
    chk({25'h0, pc}, {25'h0, p});
    chk({25'h0, sc}, {25'h0, s});
    chk({15'h0, pf}, fr(p));
    chk({15'h0, sf}, fr(s));
  endtask : sinks
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(rd, exp);
  endtask : rd_chk
  task automatic t_reset;
    rd_chk(8'h10, 32'hc0);
    rd_chk(8'ha0, 32'h80);
    rd_chk(8'hb0, 32'h80);
    sinks(7'h00, 7'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_indep;
    bus(1'b1, 8'ha0, 32'hff, 4'h1);
    bus(1'b1, 8'hb0, 32'h01, 4'h1);
    sinks(7'h7f, 7'h01);
    rd_chk(8'ha0, 32'hff);
    bus(1'b1, 8'ha0, 32'h40, 4'h1);
    rd_chk(8'ha0, 32'hc0);
    sinks(7'h40, 7'h01);
    $display("test independent done");
  endtask : t_indep
  task automatic t_unison;
    bus(1'b1, 8'h10, 32'h04, 4'h1);
    chk({31'h0, unison_select}, 32'h1);
    bus(1'b1, 8'hb0, 32'h7f, 4'h1);
    sinks(7'h40, 7'h40);
    rd_chk(8'hb0, 32'hff);
    bus(1'b1, 8'h10, 32'h00, 4'h1);
    sinks(7'h40, 7'h7f);
    $display("test unison done");
  endtask : t_unison
  task automatic t_refuse;
    bus(1'b1, 8'h20, 32'h55, 4'h1);
    rd_chk(8'h20, 32'h0);
    bus(1'b1, 8'ha0, 32'h01, 4'h0);
    rd_chk(8'ha0, 32'hc0);
    $display("test refused done");
  endtask : t_refuse
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    t_reset();
    t_indep();
    t_unison();
    t_refuse();
    wrap_up();
  end
  // Whole run needs under a thousand cycles
  initial begin
    #50000;
    n_errors++;
    wrap_up();
  end
endmodule : led_brightness_code_select_test
`default_nettype wire
